// *** inc/ftcmd_defines.vh ***
// Constants for the filter table read, delete and clear command block
`ifndef FTCMD_DEFINES_VH
`define FTCMD_DEFINES_VH

// ----------------------------------------
// Packet framing
// ----------------------------------------
`define FTC_SYNC_BYTE 8'h55
`define FTC_PKT_COMMAND 8'h05
`define FTC_PKT_RESPONSE 8'h02
`define FTC_OPT_LEN_NONE 8'h00
`define FTC_HDR_BYTES 3'h4
`define FTC_CMD_CAPTURE 3'h7
`define FTC_ENTRY_BYTES 3'h5

// ----------------------------------------
// Command codes and return codes
// ----------------------------------------
`define FTC_READ_FILTERS_CMD 8'h0F
`define FTC_DELETE_FILTER_CMD 8'h0C
`define FTC_CLEAR_FILTERS_CMD 8'h0D
`define FTC_SUCCESS_CODE 8'h00
`define FTC_LEN_SHORT_CMD 16'h0001
`define FTC_LEN_DELETE_CMD 16'h0007

// ----------------------------------------
// Filter types and condition/action codes
// ----------------------------------------
`define FTC_TYPE_SRC_ID 8'h00
`define FTC_TYPE_TELEGRAM 8'h01
`define FTC_TYPE_SIGNAL 8'h02
`define FTC_TYPE_DST_ID 8'h03
`define FTC_ACT_FWD_FALSE 8'h00
`define FTC_ACT_FWD_TRUE 8'h80
`define FTC_ACT_REP_FALSE 8'h40
`define FTC_ACT_REP_TRUE 8'hC0

// ----------------------------------------
// Table size and checksum
// ----------------------------------------
`define FTC_MAX_FILTERS 8
`define FTC_CNT_W 4
`define FTC_CRC_POLY 8'h07
`define FTC_CRC_INIT 8'h00

`endif

// *** rtl/ftcmd_crc8.v ***
// One-byte step of the packet checksum
`timescale 1ns/100ps
module ftcmd_crc8 (
  input wire [7:0] crcIn,  // Running checksum
  input wire [7:0] dataIn, // Byte to fold in
  output reg [7:0] crcOut  // Updated checksum
);
`include "ftcmd_defines.vh"
  integer i;
  reg [7:0] c;
  always @* begin
    c = crcIn ^ dataIn;
    for (i = 0; i < 8; i = i + 1) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ `FTC_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crcOut = c;
  end
endmodule // ftcmd_crc8

// *** rtl/ftcmd_core.v ***
// Filter table with read, delete and clear command handling over a byte packet link
`timescale 1ns/100ps
module ftcmd_core (
  input wire clk,              // 200 MHz clock
  input wire reset,            // Synchronous reset, active high
  input wire ce,               // Clock enable, freezes all state when low
  input wire [7:0] rxData,     // Command byte from the host link logic
  input wire rxValid,          // Command byte valid
  output reg rxReady_q,        // Command byte accepted
  output reg [7:0] txData_q,   // Response byte to the host link logic
  output reg txValid_q,        // Response byte valid
  input wire txReady,          // Link logic takes the response byte
  input wire addValid,         // Add one filter entry
  input wire [7:0] addType,    // Type of entry to add
  input wire [31:0] addValue,  // Value of entry to add
  input wire [7:0] addAction,  // Condition/action of entry to add
  output reg addReady_q,       // Entry add accepted
  output reg [3:0] filterCount_q // Entries currently held
);
`include "ftcmd_defines.vh"

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] R_SYNC = 3'h0, R_HDR = 3'h1, R_HCRC = 3'h2, R_DATA = 3'h3, R_DCRC = 3'h4;
  localparam [1:0] T_IDLE = 2'h0, T_HDR = 2'h1, T_ENT = 2'h2, T_DCRC = 2'h3;

  // ----------------------------------------
  // Filter table
  // ----------------------------------------
  reg [7:0] typeMem [0:`FTC_MAX_FILTERS-1];
  reg [31:0] valueMem [0:`FTC_MAX_FILTERS-1];
  reg [7:0] actMem [0:`FTC_MAX_FILTERS-1];

  reg [2:0] rxState_q;
  reg [16:0] rxCnt_q;
  reg [7:0] rxCrc_q;
  reg [7:0] hdr_q [0:3];
  reg [7:0] cmd_q [0:6];
  reg exec_q;
  reg [1:0] txState_q;
  reg [2:0] txPos_q;
  reg [3:0] entIdx_q;
  reg [2:0] entByte_q;
  reg [7:0] txCrc_q;
  reg [7:0] txByte;
  reg txRestart;
  reg [3:0] hitIdx;
  reg hit;
  wire [7:0] rxCrcNext;
  wire [7:0] txCrcNext;
  wire [15:0] rxDataLen = {hdr_q[0], hdr_q[1]};
  wire [16:0] rxTotal = {1'b0, rxDataLen} + {9'h000, hdr_q[2]};
  wire rxTake = ce && rxReady_q && rxValid;
  wire txLoad = (txState_q != T_IDLE) && (!txValid_q || txReady);
  wire [15:0] respLen = 16'h0001 + {12'h000, filterCount_q} * 16'h0005;
  integer i, k;
  function entryMatch;
    input [7:0] t;
    input [31:0] v;
    input [7:0] a;
    input [7:0] tc;
    input [31:0] vc;
    input [7:0] ac;
    begin
      entryMatch = (t == tc) && (v == vc) && (a == ac);
    end
  endfunction
  ftcmd_crc8 rxCrcStep (
    .crcIn(((rxState_q == R_SYNC) || (rxState_q == R_HCRC)) ? `FTC_CRC_INIT : rxCrc_q),
    .dataIn(rxData),
    .crcOut(rxCrcNext)
  );
  ftcmd_crc8 txCrcStep (
    .crcIn(txRestart ? `FTC_CRC_INIT : txCrc_q),
    .dataIn(txByte),
    .crcOut(txCrcNext)
  );

  // ----------------------------------------
  // Command receiver
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      rxState_q <= R_SYNC;
      rxCnt_q <= 17'h00000;
      rxCrc_q <= `FTC_CRC_INIT;
      exec_q <= 1'b0;
      rxReady_q <= 1'b0;
    end else if (ce) begin
      exec_q <= 1'b0;
      // Link stays shut until the last response byte is taken, so a second read cannot restart it
      rxReady_q <= (txState_q == T_IDLE) && !txValid_q && !exec_q;
      if (rxTake) begin
        case (rxState_q)
          R_SYNC: begin
            if (rxData == `FTC_SYNC_BYTE) begin
              rxState_q <= R_HDR;
              rxCnt_q <= 17'h00000;
              rxCrc_q <= `FTC_CRC_INIT;
            end
          end
          R_HDR: begin
            hdr_q[rxCnt_q[1:0]] <= rxData;
            rxCrc_q <= rxCrcNext;
            rxCnt_q <= rxCnt_q + 17'h00001;
            if (rxCnt_q[1:0] == 2'h3) begin
              rxState_q <= R_HCRC;
            end
          end
          R_HCRC: begin
            rxCnt_q <= 17'h00000;
            rxCrc_q <= `FTC_CRC_INIT;
            if (rxData == rxCrc_q && rxTotal != 17'h00000) begin
              rxState_q <= R_DATA;
            end else begin
              rxState_q <= R_SYNC;
            end
          end
          R_DATA: begin
            if (rxCnt_q < {14'h0000, `FTC_CMD_CAPTURE}) begin
              cmd_q[rxCnt_q[2:0]] <= rxData;
            end
            rxCrc_q <= rxCrcNext;
            rxCnt_q <= rxCnt_q + 17'h00001;
            if (rxCnt_q == rxTotal - 17'h00001) begin
              rxState_q <= R_DCRC;
            end
          end
          // act only on a good data checksum
          default: begin
            rxState_q <= R_SYNC;
            exec_q <= (rxData == rxCrc_q) && (hdr_q[3] == `FTC_PKT_COMMAND) && (hdr_q[2] == `FTC_OPT_LEN_NONE);
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Delete lookup
  // ----------------------------------------
  always @* begin
    hit = 1'b0;
    hitIdx = 4'h0;
    for (i = `FTC_MAX_FILTERS - 1; i >= 0; i = i - 1) begin
      if (i < filterCount_q && entryMatch(typeMem[i], valueMem[i], actMem[i],
          cmd_q[1], {cmd_q[2], cmd_q[3], cmd_q[4], cmd_q[5]}, cmd_q[6])) begin
        hit = 1'b1;
        hitIdx = i[3:0];
      end
    end
  end

  // ----------------------------------------
  // Table maintenance
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      filterCount_q <= 4'h0;
      addReady_q <= 1'b0;
    end else if (ce) begin
      // Adds wait out responses and finishing commands, so no accepted entry is lost
      addReady_q <= (txState_q == T_IDLE) && !exec_q && !addReady_q && addValid
        && (filterCount_q < `FTC_MAX_FILTERS) && !(rxTake && rxState_q == R_DCRC);
      if (exec_q && rxDataLen == `FTC_LEN_SHORT_CMD && cmd_q[0] == `FTC_CLEAR_FILTERS_CMD) begin
        filterCount_q <= 4'h0;
      end else if (exec_q && rxDataLen == `FTC_LEN_DELETE_CMD && cmd_q[0] == `FTC_DELETE_FILTER_CMD && hit) begin
        for (k = 0; k < `FTC_MAX_FILTERS - 1; k = k + 1) begin
          if (k >= hitIdx) begin
            typeMem[k] <= typeMem[k+1];
            valueMem[k] <= valueMem[k+1];
            actMem[k] <= actMem[k+1];
          end
        end
        filterCount_q <= filterCount_q - 4'h1;
      end else if (addReady_q) begin
        typeMem[filterCount_q[2:0]] <= addType;
        valueMem[filterCount_q[2:0]] <= addValue;
        actMem[filterCount_q[2:0]] <= addAction;
        filterCount_q <= filterCount_q + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Response byte selection
  // ----------------------------------------
  always @* begin
    txByte = 8'h00;
    txRestart = 1'b0;
    case (txState_q)
      T_HDR: begin
        case (txPos_q)
          3'h0: txByte = `FTC_SYNC_BYTE;
          3'h1: begin
            txByte = respLen[15:8];
            txRestart = 1'b1;
          end
          3'h2: txByte = respLen[7:0];
          3'h3: txByte = `FTC_OPT_LEN_NONE;
          3'h4: txByte = `FTC_PKT_RESPONSE;
          3'h5: txByte = txCrc_q;
          default: begin
            txByte = `FTC_SUCCESS_CODE;
            txRestart = 1'b1;
          end
        endcase
      end
      // type byte then value, high byte first
      T_ENT: begin
        case (entByte_q)
          3'h0: txByte = typeMem[entIdx_q[2:0]];
          3'h1: txByte = valueMem[entIdx_q[2:0]][31:24];
          3'h2: txByte = valueMem[entIdx_q[2:0]][23:16];
          3'h3: txByte = valueMem[entIdx_q[2:0]][15:8];
          default: txByte = valueMem[entIdx_q[2:0]][7:0];
        endcase
      end
      T_DCRC: txByte = txCrc_q;
      default: txByte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Response sender
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      txState_q <= T_IDLE;
      txPos_q <= 3'h0;
      entIdx_q <= 4'h0;
      entByte_q <= 3'h0;
      txCrc_q <= `FTC_CRC_INIT;
      txData_q <= 8'h00;
      txValid_q <= 1'b0;
    end else if (ce) begin
      if (txValid_q && txReady) begin
        txValid_q <= 1'b0;
      end
      if (txState_q == T_IDLE && exec_q && rxDataLen == `FTC_LEN_SHORT_CMD
          && cmd_q[0] == `FTC_READ_FILTERS_CMD) begin
        txState_q <= T_HDR;
        txPos_q <= 3'h0;
        entIdx_q <= 4'h0;
        entByte_q <= 3'h0;
      end else if (txLoad) begin
        txData_q <= txByte;
        txValid_q <= 1'b1;
        if (txState_q != T_DCRC && !(txState_q == T_HDR && txPos_q == 3'h5)) begin
          txCrc_q <= txCrcNext;
        end
        case (txState_q)
          T_HDR: begin
            txPos_q <= txPos_q + 3'h1;
            if (txPos_q == 3'h6) begin
              txState_q <= (filterCount_q == 4'h0) ? T_DCRC : T_ENT;
            end
          end
          T_ENT: begin
            if (entByte_q == `FTC_ENTRY_BYTES - 3'h1) begin
              entByte_q <= 3'h0;
              entIdx_q <= entIdx_q + 4'h1;
              if (entIdx_q == filterCount_q - 4'h1) begin
                txState_q <= T_DCRC;
              end
            end else begin
              entByte_q <= entByte_q + 3'h1;
            end
          end
          default: txState_q <= T_IDLE;
        endcase
      end
    end
  end
endmodule // ftcmd_core

// *** verification/ftcmd_core_assertions.sv ***
// Port checks for the filter table command block
`timescale 1ns/100ps
module ftcmd_core_assertions (
  input wire clk, // Clock
  input wire reset, // Sync reset
  input wire ce, // Clock enable
  input wire [7:0] rxData, // Command byte
  input wire rxValid, // Command valid
  input wire rxReady_q, // Command taken
  input wire [7:0] txData_q, // Response byte
  input wire txValid_q, // Response valid
  input wire txReady, // Response taken
  input wire addValid, // Add request
  input wire [7:0] addType, // Add type
  input wire [31:0] addValue, // Add value
  input wire [7:0] addAction, // Add action
  input wire addReady_q, // Add accepted
  input wire [3:0] filterCount_q // Entries held
);
  logic [5:0] txIdx_q;
  // Position of the response byte on offer
  always @(posedge clk)
    if (reset || rxReady_q) txIdx_q <= 6'h00;
    else if (ce && txValid_q && txReady) txIdx_q <= txIdx_q + 6'h01;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_resp_sync: assert property (
    $rose(txValid_q) |-> txData_q == 8'h55) else $error("response not opened by sync");
  a_resp_lenhi: assert property (
    txValid_q && txIdx_q == 6'h01 |-> txData_q == 8'h00) else $error("length high byte");
  a_resp_lenlo: assert property (
    txValid_q && txIdx_q == 6'h02 |-> txData_q == 8'h01 + 8'h05 * {4'h0, filterCount_q})
    else $error("length low byte");
  a_resp_optlen: assert property (
    txValid_q && txIdx_q == 6'h03 |-> txData_q == 8'h00) else $error("optional length");
  a_resp_type: assert property (
    txValid_q && txIdx_q == 6'h04 |-> txData_q == 8'h02) else $error("packet type");
  a_resp_code: assert property (
    txValid_q && txIdx_q == 6'h06 |-> txData_q == 8'h00) else $error("return code");
  a_tx_hold: assert property (
    txValid_q && !(txReady && ce) |=> txValid_q && $stable(txData_q)) else $error("byte dropped");
  a_rx_blocked: assert property (
    txValid_q |-> !rxReady_q) else $error("input open while answering");
  a_count_nogrow: assert property (
    !addReady_q |=> filterCount_q <= $past(filterCount_q)) else $error("count grew");
  a_count_bound: assert property (
    filterCount_q <= 4'h8) else $error("count above depth");
endmodule // ftcmd_core_assertions
bind ftcmd_core ftcmd_core_assertions chk_u (.clk(clk), .reset(reset), .ce(ce), .rxData(rxData),
  .rxValid(rxValid), .rxReady_q(rxReady_q), .txData_q(txData_q), .txValid_q(txValid_q),
  .txReady(txReady), .addValid(addValid), .addType(addType), .addValue(addValue),
  .addAction(addAction), .addReady_q(addReady_q), .filterCount_q(filterCount_q));

// *** verification/ftcmd_host_model.sv ***
// Host side of the packet link: byte source and response sink
`timescale 1ns/100ps
module ftcmd_host_model (
  input wire logic clk, // Clock
  input wire logic rxReady_q, // Device takes bytes
  input wire logic [7:0] txData_q, // Response byte
  input wire logic txValid_q, // Response valid
  output logic [7:0] rxData, // Command byte
  output logic rxValid, // Command valid
  output logic txReady // Sink ready
);
  logic [7:0] seen[$];
  logic slowSink = 1'b0;
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b1;
  end
  always @(posedge clk)
    if (txValid_q && txReady) seen.push_back(txData_q);
  // Stalls every other cycle in slow mode
  always @(negedge clk) txReady <= slowSink ? ~txReady : 1'b1;
  task automatic send_byte(logic [7:0] b);
    @(negedge clk);
    rxData = b;
    rxValid = 1'b1;
    do @(posedge clk); while (rxReady_q !== 1'b1);
  endtask
  // Released line shows the inverse, not the stale byte
  task automatic idle;
    @(negedge clk);
    rxValid = 1'b0;
    rxData = ~rxData;
  endtask
endmodule // ftcmd_host_model

// *** verification/ftcmd_core_bench.sv ***
// Self-checking bench for the filter table command block
`timescale 1ns/100ps
module ftcmd_core_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic addValid = 1'b0;
  logic [7:0] addType = 8'h00;
  logic [7:0] addAction = 8'h00;
  logic [31:0] addValue = 32'h00000000;
  wire [7:0] rxData, txData_q;
  wire rxValid, rxReady_q, txValid_q, txReady, addReady_q;
  wire [3:0] filterCount_q;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [7:0] mType[$], mAct[$];
  logic [31:0] mVal[$];
  logic [7:0] acts[4] = '{8'h00, 8'h80, 8'h40, 8'hC0};
  always #2.5 clk = ~clk;
  ftcmd_core dut_u (.clk(clk), .reset(reset), .ce(ce), .rxData(rxData), .rxValid(rxValid),
    .rxReady_q(rxReady_q), .txData_q(txData_q), .txValid_q(txValid_q), .txReady(txReady),
    .addValid(addValid), .addType(addType), .addValue(addValue), .addAction(addAction),
    .addReady_q(addReady_q), .filterCount_q(filterCount_q));
  ftcmd_host_model host_u (.clk(clk), .rxReady_q(rxReady_q), .txData_q(txData_q),
    .txValid_q(txValid_q), .rxData(rxData), .rxValid(rxValid), .txReady(txReady));
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
    c = c ^ d;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send_pkt(logic [7:0] d[$], bit badHdr, bit badDat);
    logic [7:0] p[$];
    logic [7:0] c;
    p = {8'h55, 8'h00, 8'(d.size()), 8'h00, 8'h05};
    c = 8'h00;
    for (int i = 1; i < 5; i++) c = crc8(c, p[i]);
    p.push_back(c ^ {7'h00, badHdr});
    c = 8'h00;
    foreach (d[i]) c = crc8(c, d[i]);
    p = {p, d, c ^ {7'h00, badDat}};
    foreach (p[i]) host_u.send_byte(p[i]);
    host_u.idle();
    repeat (4) @(posedge clk);
  endtask
  task automatic read_check;
    logic [7:0] d[$];
    logic [7:0] e[$];
    logic [7:0] c;
    int n;
    d = {8'h00};
    foreach (mType[i]) d = {d, mType[i], mVal[i][31:24], mVal[i][23:16], mVal[i][15:8], mVal[i][7:0]};
    e = {8'h55, 8'h00, 8'(d.size()), 8'h00, 8'h02};
    c = 8'h00;
    for (int i = 1; i < 5; i++) c = crc8(c, e[i]);
    e.push_back(c);
    c = 8'h00;
    foreach (d[i]) c = crc8(c, d[i]);
    e = {e, d, c};
    host_u.seen.delete();
    send_pkt({8'h0F}, 1'b0, 1'b0);
    n = 0;
    while (host_u.seen.size() < e.size() && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
    check("response length", host_u.seen.size(), e.size());
    foreach (e[i]) check("response byte", host_u.seen[i], e[i]);
  endtask
  task automatic add_entry(logic [7:0] t, logic [31:0] v, logic [7:0] a);
    int n;
    @(negedge clk);
    addValid = 1'b1;
    addType = t;
    addValue = v;
    addAction = a;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (addReady_q !== 1'b1 && n < 50);
    @(negedge clk);
    addValid = 1'b0;
    addValue = ~v;
    mType.push_back(t);
    mVal.push_back(v);
    mAct.push_back(a);
  endtask
  task automatic test_full;
    send_pkt({8'h0D}, 1'b0, 1'b0);
    check("count after clear", filterCount_q, 0);
    for (int i = 0; i < 8; i++)
      add_entry(8'(i % 4), (i % 4 == 1 || i % 4 == 2) ? 32'h40 + i : 32'hA1B2C300 + i, acts[i % 4]);
    check("count full", filterCount_q, 8);
    host_u.slowSink = 1'b1;
    read_check();
    host_u.slowSink = 1'b0;
    $display("test full table done");
  endtask
  task automatic test_delete;
    send_pkt({8'h0C, mType[2], mVal[2][31:24], mVal[2][23:16], mVal[2][15:8], mVal[2][7:0], 8'h80},
      1'b0, 1'b0);
    check("count after near miss", filterCount_q, 8);
    send_pkt({8'h0C, mType[2], mVal[2][31:24], mVal[2][23:16], mVal[2][15:8], mVal[2][7:0], mAct[2]},
      1'b0, 1'b0);
    check("count after delete", filterCount_q, 7);
    mType.delete(2);
    mVal.delete(2);
    mAct.delete(2);
    read_check();
    $display("test delete done");
  endtask
  task automatic test_bad;
    send_pkt({8'h0D}, 1'b0, 1'b1);
    check("count after bad data sum", filterCount_q, 7);
    send_pkt({8'h0D}, 1'b1, 1'b0);
    check("count after bad header sum", filterCount_q, 7);
    host_u.seen.delete();
    send_pkt({8'h0F}, 1'b0, 1'b1);
    repeat (40) @(posedge clk);
    check("answer to bad read", host_u.seen.size(), 0);
    send_pkt({8'h0D}, 1'b0, 1'b0);
    check("count after clear", filterCount_q, 0);
    mType.delete();
    mVal.delete();
    mAct.delete();
    read_check();
    $display("test bad packets done");
  endtask
  task automatic test_freeze;
    @(negedge clk);
    ce = 1'b0;
    addValid = 1'b1;
    addType = 8'h03;
    addValue = 32'h5A6B7C8D;
    addAction = 8'hC0;
    repeat (6) @(posedge clk);
    check("add ready while frozen", addReady_q, 0);
    check("count while frozen", filterCount_q, 0);
    @(negedge clk);
    ce = 1'b1;
    addValid = 1'b0;
    add_entry(8'h03, 32'h5A6B7C8D, 8'hC0);
    read_check();
    $display("test freeze done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    check("count after reset", filterCount_q, 0);
    read_check();
    test_full();
    test_delete();
    test_bad();
    test_freeze();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
endmodule // ftcmd_core_bench
